//--- testbench/tb_tlb_terminal_io.sv
// self-checking bench for the terminal logic io block
`timescale 1ns/1ns
module tb_tlb_terminal_io;
  import tlb_pkg::*;
  logic clk = 0, rst = 1, wr = 0, rd = 0, stop = 0, run = 0, pres = 1, tgt;
  logic [3:0] addr = 0, chan = 0, dip = 0, fld = 0, lvl, out, oe, res;
  logic [15:0] wd = 0, rdata;
  logic [63:0] src = 0;
  tlb_route_t [NUM_IN-1:0] inr;
  tlb_route_t [NUM_DIO-1:0] dior;
  int bad_count = 0, n_checks = 0, cyc = 0;
  initial forever #4 clk = ~clk;
  tlb_terminal_io tlb_terminal_io_i (.i_clk(clk), .i_sys_rst(rst), .i_addr(addr), .i_chan(chan),
    .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_drive_stopped(stop),
    .i_logic_input(dip), .i_run_terminal_input(run), .i_run_terminal_present(pres),
    .i_source_value(src), .i_bidir_terminal_in(lvl), .o_bidir_terminal_out(out),
    .o_bidir_terminal_oe(oe), .o_dio_result(res), .o_in_route(inr), .o_dio_route(dior),
    .o_internal_run_target(tgt));
  tlb_field_model tlb_field_model_i (.i_fld(fld), .i_drv(out), .i_oe(oe), .o_lvl(lvl));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string nm);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // one strobe cycle; read data is sampled in the cycle after
  task automatic bus(input logic w, input logic [3:0] a, c, input logic [15:0] d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    chan <= c;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
  endtask : bus
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask : settle
  task automatic sv(input int c, input logic [15:0] v);
    @(posedge clk);
    src[c*16+:16] <= v;
    settle;
  endtask : sv
  task automatic t_defaults;
    logic [23:0] tv[8] = '{24'h040001, 24'h140000, 24'h240134, 24'h200190, 24'h310000,
      24'h420001, 24'h630000, 24'h500000};
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, tv[i][23:20], tv[i][19:16], 16'h0000);
      chk(rdata, tv[i][15:0], "reset value");
    end
    $display("defaults done");
  endtask : t_defaults
  task automatic t_run;
    @(posedge clk);
    run <= 1'b1;
    settle;
    chk(inr[RUN_IDX].value, HI_LEVEL_RST, "run high");
    chk({15'h0, tgt}, 16'h0001, "run target");
    bus(1'b1, CFG_IN_HI, 4'h4, 16'h7531);
    bus(1'b0, CFG_IN_HI, 4'h4, 16'h0000);
    chk(rdata, LVL_MAX, "high clamp");
    @(posedge clk);
    run <= 1'b0;
    settle;
    chk({inr[RUN_IDX].value[14:0], tgt}, 16'h0000, "run low");
    bus(1'b1, CFG_IN_LO, 4'h4, 16'h8acf);
    bus(1'b0, CFG_IN_LO, 4'h4, 16'h0000);
    chk(rdata, LVL_MIN, "low clamp");
    settle;
    chk({15'h0, tgt}, 16'h0001, "negative reads high");
    @(posedge clk);
    pres <= 1'b0;
    settle;
    chk(inr[RUN_IDX].value, LVL_MAX, "run open");
    $display("run done");
  endtask : t_run
  task automatic t_dest;
    bus(1'b1, CFG_IN_DEST, 4'h0, 16'h02d0);
    bus(1'b1, CFG_IN_DEST, 4'h0, 16'h02d1);
    bus(1'b0, CFG_IN_DEST, 4'h0, 16'h0000);
    chk(rdata, 16'h02d0, "dest limit");
    @(posedge clk);
    dip <= 4'h1;
    settle;
    chk({inr[0].value[5:0], inr[0].dest}, 16'h06d0, "route");
    $display("dest done");
  endtask : t_dest
  task automatic t_cmp;
    for (int c = 0; c < NUM_DIO; c++) begin
      bus(1'b1, CFG_DIO_THRESH, c[3:0], 16'h0064);
      sv(c, 16'hff9b);
      chk({15'h0, res[c]}, 16'h0001, "rectified");
      sv(c, 16'h0064);
      chk({15'h0, res[c]}, 16'h0000, "equal");
      bus(1'b1, CFG_DIO_RECT, c[3:0], 16'h0000);
      sv(c, 16'hff9b);
      chk({15'h0, res[c]}, 16'h0000, "bipolar");
      bus(1'b1, CFG_DIO_INV, c[3:0], 16'h0001);
      settle;
      chk({15'h0, res[c]}, 16'h0001, "inverted");
    end
    $display("compare done");
  endtask : t_cmp
  task automatic t_mode;
    bus(1'b1, CFG_DIO_MODE, 4'h0, 16'h0001);
    @(posedge clk);
    fld <= 4'h1;
    settle;
    bus(1'b0, CFG_STATUS, 4'h0, 16'h0000);
    chk({rdata[15:12], rdata[8], oe}, 16'h01f0, "open switch");
    chk(dior[0].value, HI_LEVEL_RST, "sensed route");
    chk({6'h00, dior[0].dest}, 16'h0190, "sensed dest");
    @(posedge clk);
    fld <= 4'h0;
    stop <= 1'b1;
    settle;
    bus(1'b0, CFG_STATUS, 4'h0, 16'h0000);
    chk({rdata[8], oe[0], out[0]}, 16'h0007, "driven");
    $display("mode done");
  endtask : t_mode
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_defaults;
    t_run;
    t_dest;
    t_cmp;
    t_mode;
    test_done;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      test_done;
    end
  end
endmodule : tb_tlb_terminal_io

//--- testbench/tlb_field_model.sv
// field wiring model on the bidirectional terminals
`timescale 1ns/1ns
module tlb_field_model (
  input wire logic [3:0] i_fld,
  input wire logic [3:0] i_drv,
  input wire logic [3:0] i_oe,
  output logic [3:0] o_lvl
);
  // a closed switch overrides the field contact
  assign o_lvl = (i_oe & i_drv) | (~i_oe & i_fld);
endmodule : tlb_field_model

//--- testbench/tlb_terminal_io_chk.sv
// port checker for the terminal logic io block
`timescale 1ns/1ns
module tlb_terminal_io_chk
  import tlb_pkg::*;
#(parameter int NUM_DIP = 4) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_rd,
  input wire logic i_drive_stopped,
  input wire logic [15:0] o_rdata,
  input wire logic [NUM_DIO-1:0] o_bidir_terminal_out,
  input wire logic [NUM_DIO-1:0] o_bidir_terminal_oe,
  input wire logic [NUM_DIO-1:0] o_dio_result,
  input wire tlb_route_t [NUM_IN-1:0] o_in_route,
  input wire logic o_internal_run_target
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  logic dest_bad;
  always_comb begin
    dest_bad = 1'b0;
    for (int i = 0; i < NUM_IN; i++) dest_bad |= (o_in_route[i].dest > DEST_MAX);
  end
  sequence s_rel; $fell(i_sys_rst); endsequence
  sequence s_stop; $past(i_drive_stopped); endsequence
  property p_rst_clear; s_rel |-> o_bidir_terminal_oe == 4'h0 && o_dio_result == 4'h0
    && o_in_route[RUN_IDX].dest == DEST_INTERNAL_RUN; endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("reset state wrong");
  property p_oe_hold; !$past(i_drive_stopped) |-> $stable(o_bidir_terminal_oe); endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("mode moved while running");
  property p_oe_rise; $rose(o_bidir_terminal_oe[0]) |-> s_stop; endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("switch closed while running");
  property p_out_gate; o_bidir_terminal_out == (o_dio_result & o_bidir_terminal_oe); endproperty
  a_out_gate: assert property (p_out_gate) else $error("drive value wrong");
  property p_open_quiet; o_bidir_terminal_oe == 4'h0 |-> o_bidir_terminal_out == 4'h0; endproperty
  a_open_quiet: assert property (p_open_quiet) else $error("open switch drives");
  property p_run_tgt; o_internal_run_target == (o_in_route[RUN_IDX].dest == DEST_INTERNAL_RUN
    && o_in_route[RUN_IDX].value != 16'h0000); endproperty
  a_run_tgt: assert property (p_run_tgt) else $error("run target wrong");
  property p_dest_rng; !dest_bad; endproperty
  a_dest_rng: assert property (p_dest_rng) else $error("destination out of span");
  property p_rd_idle; !$past(i_rd) |-> o_rdata == 16'h0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside window");
endmodule : tlb_terminal_io_chk
bind tlb_terminal_io tlb_terminal_io_chk #(.NUM_DIP(NUM_DIP)) tlb_terminal_io_chk_i (
  .i_clk, .i_sys_rst, .i_rd, .i_drive_stopped, .o_rdata, .o_bidir_terminal_out,
  .o_bidir_terminal_oe, .o_dio_result, .o_in_route, .o_internal_run_target);

//--- verilog/tlb_pkg.sv
// package for the terminal logic io block: settings, defaults and carriers
package tlb_pkg;
  localparam int VAL_W = 16;
  localparam int DEST_W = 10;
  localparam logic [15:0] LVL_MAX = 16'h7530;
  localparam logic [15:0] LVL_MIN = 16'h8ad0;
  localparam logic [15:0] HI_LEVEL_RST = 16'h0001;
  localparam logic [15:0] LO_LEVEL_RST = 16'h0000;
  localparam logic [15:0] THRESH_RST = 16'h0000;
  localparam logic [9:0] DEST_MAX = 10'h2d0;
  localparam logic [9:0] DEST_DISCONNECT = 10'h190;
  localparam logic [9:0] DEST_INTERNAL_RUN = 10'h134;
  localparam logic RECTIFY_RST = 1'b1;
  localparam logic INVERT_RST = 1'b0;
  localparam logic DRIVE_MODE_RST = 1'b0;
  localparam int NUM_IN = 5;
  localparam int RUN_IDX = 4;
  localparam int NUM_DIO = 4;
  localparam logic [3:0] CFG_IN_HI = 4'h0;
  localparam logic [3:0] CFG_IN_LO = 4'h1;
  localparam logic [3:0] CFG_IN_DEST = 4'h2;
  localparam logic [3:0] CFG_DIO_MODE = 4'h3;
  localparam logic [3:0] CFG_DIO_RECT = 4'h4;
  localparam logic [3:0] CFG_DIO_THRESH = 4'h5;
  localparam logic [3:0] CFG_DIO_INV = 4'h6;
  localparam logic [3:0] CFG_DIO_HI = 4'h7;
  localparam logic [3:0] CFG_DIO_LO = 4'h8;
  localparam logic [3:0] CFG_STATUS = 4'h9;

  typedef struct packed {
    logic [15:0] value;
    logic [9:0] dest;
  } tlb_route_t;

  typedef struct packed {
    logic drive_mode;
    logic rectify;
    logic invert;
    logic [15:0] thresh;
    logic [15:0] hi_level;
    logic [15:0] lo_level;
  } tlb_dio_cfg_t;
endpackage : tlb_pkg

//--- verilog/tlb_terminal_io.sv
// terminal logic io block: logic inputs, run input and four bidirectional terminals
`timescale 1ns/1ns
//
// Function
// - each logic input routes its value to a destination number 000 to 720.
// - run terminal high outputs run high level, range +-300%, default 0.01%.
// - run terminal low outputs run low level, default 0.00%.
// - run input defaults to internal run destination 308, held high if disconnected.
// - four bidirectional channels each with their own full setting set.
// - output mode disabled keeps switch open; processed result still available.
// - output mode enabled keeps switch closed; terminal driven by output path.
// - input sensing reports terminal level at all times.
// - output mode is a two-value enable, reset default disabled.
// - output mode change takes effect only while the drive is stopped.
// - each channel output compares a selected internal signal against its threshold.
// - rectify defaults enabled and compares signal magnitude.
// - rectify disabled compares the signed signal directly.
// - rectify setting is per channel and affects the output comparison only.
// - logic use reads exactly zero as low, any nonzero value as high.
// - comparator is high only when signal strictly exceeds threshold.
// - per-channel invert setting, default non-inverting.
module tlb_terminal_io
  import tlb_pkg::*;
#(
  parameter int NUM_DIP = 4
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [3:0] i_addr,
  input wire logic [3:0] i_chan,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  input wire logic i_drive_stopped,
  input wire logic [NUM_DIP-1:0] i_logic_input,
  input wire logic i_run_terminal_input,
  input wire logic i_run_terminal_present,
  input wire logic [NUM_DIO*16-1:0] i_source_value,
  input wire logic [NUM_DIO-1:0] i_bidir_terminal_in,
  output logic [NUM_DIO-1:0] o_bidir_terminal_out,
  output logic [NUM_DIO-1:0] o_bidir_terminal_oe,
  output logic [NUM_DIO-1:0] o_dio_result,
  output tlb_route_t [NUM_IN-1:0] o_in_route,
  output tlb_route_t [NUM_DIO-1:0] o_dio_route,
  output logic o_internal_run_target
);

  localparam int NIN = NUM_DIP + 1;
  localparam int RUN = NUM_DIP;

  // the read layout and the channel decode are built for these sizes
  generate
    if (NUM_DIP != 4 || NIN != NUM_IN) begin : g_bad_dip
      $error("tlb_terminal_io: only four logic inputs are supported");
    end
    if (VAL_W != 16 || DEST_W != 10) begin : g_bad_width
      $error("tlb_terminal_io: levels are 16 bits and destinations 10 bits");
    end
    if (NUM_DIO != 4 || RUN_IDX != RUN) begin : g_bad_dio
      $error("tlb_terminal_io: four channels and the run input last are required");
    end
    if ($signed(LVL_MAX) <= 0 || DEST_INTERNAL_RUN > DEST_MAX) begin : g_bad_const
      $error("tlb_terminal_io: level span or run destination out of range");
    end
  endgenerate

  // clamp a written level to the +-300.00% span
  function automatic logic [15:0] clamp_level(input logic [15:0] v);
    if ($signed(v) > $signed(LVL_MAX)) begin
      return LVL_MAX;
    end else if ($signed(v) < $signed(LVL_MIN)) begin
      return LVL_MIN;
    end
    return v;
  endfunction : clamp_level

  // unsigned magnitude; most negative code saturates
  function automatic logic [15:0] magnitude(input logic [15:0] v);
    if (v[15]) begin
      return (v == 16'h8000) ? 16'h7fff : 16'((~v) + 16'h0001);
    end
    return v;
  endfunction : magnitude

  // destination number inside the span, no stray upper bits
  function automatic logic dest_ok(input logic [15:0] v);
    return (v[9:0] <= DEST_MAX) && (v[15:10] == 6'h00);
  endfunction : dest_ok

  // settings held per logic or run input
  function automatic logic is_in_addr(input logic [3:0] a);
    return (a == CFG_IN_HI) || (a == CFG_IN_LO) || (a == CFG_IN_DEST);
  endfunction : is_in_addr

  // settings held per bidirectional channel
  function automatic logic is_dio_addr(input logic [3:0] a);
    return (a >= CFG_DIO_MODE) && (a <= CFG_DIO_LO);
  endfunction : is_dio_addr

  // rectified: magnitude against the signed threshold, so both signs switch alike
  function automatic logic above_rect(input logic [15:0] s, input logic [15:0] t);
    return $signed({1'b0, magnitude(s)}) > $signed({t[15], t});
  endfunction : above_rect

  // bipolar: one switching point across the signed range; equal stays low
  function automatic logic above_bipolar(input logic [15:0] s, input logic [15:0] t);
    return $signed(s) > $signed(t);
  endfunction : above_bipolar

  // read view of one input's settings
  function automatic logic [15:0] in_field_rd(input logic [3:0] a, input logic [15:0] hi,
      input logic [15:0] lo, input logic [9:0] dest);
    case (a)
      CFG_IN_HI: return hi;
      CFG_IN_LO: return lo;
      default: return {6'h00, dest};
    endcase
  endfunction : in_field_rd

  // read view of one channel's settings; mode shows applied then pending
  function automatic logic [15:0] dio_field_rd(input logic [3:0] a, input tlb_dio_cfg_t cfg,
      input logic pend);
    case (a)
      CFG_DIO_MODE: return {14'h0000, cfg.drive_mode, pend};
      CFG_DIO_RECT: return {15'h0000, cfg.rectify};
      CFG_DIO_THRESH: return cfg.thresh;
      CFG_DIO_INV: return {15'h0000, cfg.invert};
      CFG_DIO_HI: return cfg.hi_level;
      CFG_DIO_LO: return cfg.lo_level;
      default: return 16'h0000;
    endcase
  endfunction : dio_field_rd

  // status word: compare results, sensed channel levels, sampled input states
  function automatic logic [15:0] status_word(input logic [3:0] res, input logic [3:0] dio,
      input logic [4:0] ins);
    return {res, dio, 3'h0, ins};
  endfunction : status_word

  logic [15:0] in_hi_ff [NIN];
  logic [15:0] in_lo_ff [NIN];
  logic [9:0] in_dest_ff [NIN];
  logic [NIN-1:0] in_state_ff;
  tlb_dio_cfg_t dio_cfg_ff [NUM_DIO];
  logic [NUM_DIO-1:0] mode_req_ff;
  logic [NUM_DIO-1:0] bidir_state_ff;
  logic [NUM_DIO-1:0] cmp_ff;
  logic [15:0] rdata_ff;
  logic [15:0] nxt_rdata;
  logic [15:0] wval;
  logic [NIN-1:0] pin_now;
  logic wr_in_ok;
  logic wr_dio_ok;
  logic [2:0] chan_in;
  logic [1:0] chan_dio;
  // registered route carriers
  tlb_route_t [NIN-1:0] in_route_ff;
  tlb_route_t [NIN-1:0] nxt_in_route;
  tlb_route_t [NUM_DIO-1:0] dio_route_ff;
  tlb_route_t [NUM_DIO-1:0] nxt_dio_route;
  logic run_tgt_ff;
  logic nxt_run_tgt;
  logic [NIN-1:0] nxt_in_state;
  logic [NUM_DIO-1:0] nxt_bidir_state;
  logic rd_in_sel;
  logic rd_dio_sel;

  assign wval = clamp_level(i_wdata);
  assign wr_in_ok = i_wr && is_in_addr(i_addr) && (i_chan < 4'(NIN));
  assign wr_dio_ok = i_wr && is_dio_addr(i_addr) && (i_chan < 4'(NUM_DIO));
  assign chan_in = i_chan[2:0];
  assign chan_dio = i_chan[1:0];
  // a missing run terminal reads high so the internal run target stays asserted
  assign pin_now = {i_run_terminal_input | ~i_run_terminal_present, i_logic_input};
  // inputs are taken as synchronous to the clock, so one flop per terminal suffices
  assign nxt_in_state = pin_now;
  assign nxt_bidir_state = i_bidir_terminal_in;

  // logic input and run input settings, one process per input
  generate
    for (genvar k = 0; k < NIN; k++) begin : g_in_cfg
      logic sel;
      assign sel = wr_in_ok && (chan_in == 3'(k));
      always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
          in_hi_ff[k] <= HI_LEVEL_RST;
          in_lo_ff[k] <= LO_LEVEL_RST;
          in_dest_ff[k] <= (k == RUN) ? DEST_INTERNAL_RUN : DEST_DISCONNECT;
        end else if (sel) begin
          case (i_addr)
            CFG_IN_HI: in_hi_ff[k] <= wval;
            CFG_IN_LO: in_lo_ff[k] <= wval;
            CFG_IN_DEST: begin
              // out-of-span numbers are refused, the old target stays
              if (dest_ok(i_wdata)) begin
                in_dest_ff[k] <= i_wdata[9:0];
              end
            end
            default: ;
          endcase
        end
      end
    end
  endgenerate

  // bidirectional channel settings, one process per channel
  generate
    for (genvar c = 0; c < NUM_DIO; c++) begin : g_dio_cfg
      logic sel;
      assign sel = wr_dio_ok && (chan_dio == 2'(c));
      always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
          dio_cfg_ff[c].drive_mode <= DRIVE_MODE_RST;
          dio_cfg_ff[c].rectify <= RECTIFY_RST;
          dio_cfg_ff[c].invert <= INVERT_RST;
          dio_cfg_ff[c].thresh <= THRESH_RST;
          dio_cfg_ff[c].hi_level <= HI_LEVEL_RST;
          dio_cfg_ff[c].lo_level <= LO_LEVEL_RST;
          mode_req_ff[c] <= DRIVE_MODE_RST;
        end else begin
          if (sel) begin
            case (i_addr)
              CFG_DIO_MODE: mode_req_ff[c] <= i_wdata[0];
              CFG_DIO_RECT: dio_cfg_ff[c].rectify <= i_wdata[0];
              CFG_DIO_THRESH: dio_cfg_ff[c].thresh <= wval;
              CFG_DIO_INV: dio_cfg_ff[c].invert <= i_wdata[0];
              CFG_DIO_HI: dio_cfg_ff[c].hi_level <= wval;
              CFG_DIO_LO: dio_cfg_ff[c].lo_level <= wval;
              default: ;
            endcase
          end
          // a requested mode waits until the drive stops; running keeps the old one
          if (i_drive_stopped) begin
            dio_cfg_ff[c].drive_mode <= mode_req_ff[c];
          end
        end
      end
    end
  endgenerate

  // terminal sampling, once per update cycle
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      in_state_ff <= '0;
      bidir_state_ff <= '0;
    end else begin
      in_state_ff <= nxt_in_state;
      bidir_state_ff <= nxt_bidir_state;
    end
  end

  // output comparison path per channel
  generate
    for (genvar c = 0; c < NUM_DIO; c++) begin : g_dio
      logic [15:0] src;
      logic [15:0] thr;
      logic gt;
      logic res;
      assign src = i_source_value[c*16 +: 16];
      assign thr = dio_cfg_ff[c].thresh;
      always_comb begin
        if (dio_cfg_ff[c].rectify) begin
          gt = above_rect(src, thr);
        end else begin
          gt = above_bipolar(src, thr);
        end
        res = gt ^ dio_cfg_ff[c].invert;
      end
      always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
          cmp_ff[c] <= 1'b0;
        end else begin
          cmp_ff[c] <= res;
        end
      end
      // switch closed only in output mode; result always exported
      assign o_bidir_terminal_oe[c] = dio_cfg_ff[c].drive_mode;
      assign o_bidir_terminal_out[c] = cmp_ff[c] & dio_cfg_ff[c].drive_mode;
      assign o_dio_result[c] = cmp_ff[c];
      assign nxt_dio_route[c].value = bidir_state_ff[c] ?
          dio_cfg_ff[c].hi_level : dio_cfg_ff[c].lo_level;
      assign nxt_dio_route[c].dest = DEST_DISCONNECT;
    end
    for (genvar i = 0; i < NIN; i++) begin : g_in
      assign nxt_in_route[i].value = in_state_ff[i] ? in_hi_ff[i] : in_lo_ff[i];
      assign nxt_in_route[i].dest = in_dest_ff[i];
    end
  endgenerate

  // logic reading of the run route: zero is low, any other value high
  assign nxt_run_tgt = (in_dest_ff[RUN] == DEST_INTERNAL_RUN) &&
      (nxt_in_route[RUN].value != 16'h0000);

  // routes leave through flip-flops; the run target is taken from the same
  // values so the two never disagree for a cycle
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      for (int k = 0; k < NIN; k++) begin
        in_route_ff[k].value <= LO_LEVEL_RST;
        in_route_ff[k].dest <= (k == RUN) ? DEST_INTERNAL_RUN : DEST_DISCONNECT;
      end
      for (int k = 0; k < NUM_DIO; k++) begin
        dio_route_ff[k].value <= LO_LEVEL_RST;
        dio_route_ff[k].dest <= DEST_DISCONNECT;
      end
      run_tgt_ff <= 1'b0;
    end else begin
      in_route_ff <= nxt_in_route;
      dio_route_ff <= nxt_dio_route;
      run_tgt_ff <= nxt_run_tgt;
    end
  end

  assign o_in_route = in_route_ff;
  assign o_dio_route = dio_route_ff;
  assign o_internal_run_target = run_tgt_ff;

  // register read port, data one cycle after the strobe
  assign rd_in_sel = is_in_addr(i_addr) && (i_chan < 4'(NIN));
  assign rd_dio_sel = is_dio_addr(i_addr) && (i_chan < 4'(NUM_DIO));
  always_comb begin
    nxt_rdata = 16'h0000;
    if (i_addr == CFG_STATUS) begin
      nxt_rdata = status_word(o_dio_result, bidir_state_ff, in_state_ff);
    end else if (rd_in_sel) begin
      nxt_rdata = in_field_rd(i_addr, in_hi_ff[chan_in], in_lo_ff[chan_in], in_dest_ff[chan_in]);
    end else if (rd_dio_sel) begin
      nxt_rdata = dio_field_rd(i_addr, dio_cfg_ff[chan_dio], mode_req_ff[chan_dio]);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rdata_ff <= 16'h0000;
    end else if (i_rd) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= 16'h0000;
    end
  end

  assign o_rdata = rdata_ff;

endmodule : tlb_terminal_io
